// >>> pirq_cfg.svh
// register map, field positions and reset values of the peripheral irq block
`ifndef PIRQ_CFG_SVH
`define PIRQ_CFG_SVH

// byte offsets on the bus
`define PIRQ_OFF_EN_TWO    8'h00
`define PIRQ_OFF_PRI_ONE   8'h04
`define PIRQ_OFF_RST_CTRL  8'h08
`define PIRQ_OFF_STAT      8'h0c
`define PIRQ_OFF_MASK      8'h10

// enable register two fields
`define PIRQ_BIT_OSC_FAIL_EN  7
`define PIRQ_BIT_USB_EN       5
`define PIRQ_BIT_VDET_EN      2
`define PIRQ_EN_TWO_MASK      8'ha4
`define PIRQ_EN_TWO_RST       8'h00

// priority register one fields
`define PIRQ_BIT_CONV_PRI     6
`define PIRQ_BIT_SRX_PRI      5
`define PIRQ_BIT_STX_PRI      4
`define PIRQ_BIT_CCMP_PRI     2
`define PIRQ_BIT_TMATCH_PRI   1
`define PIRQ_BIT_TOVF_PRI     0
`define PIRQ_PRI_ONE_MASK     8'h77
`define PIRQ_PRI_ONE_RST      8'h77

// reset-control register, only the priority enable lives here
`define PIRQ_BIT_GLOBAL_PRI   7
`define PIRQ_RST_CTRL_MASK    8'h80
`define PIRQ_RST_CTRL_RST     8'h00

// event status and mask: bit 1 high line rose, bit 0 low line rose
`define PIRQ_EVT_W            2
`define PIRQ_EVT_MASK_RST     2'h0
`define PIRQ_EVT_HIGH         1
`define PIRQ_EVT_LOW          0

`define PIRQ_NUM_SRC          9
`define PIRQ_HSIZE_WORD       3'h2

`endif

// >>> pirq_pkg.sv
// types shared by the peripheral irq block
`include "pirq_cfg.svh"
package pirq_pkg;

  typedef struct packed {
    logic [7:0]              en_two;
    logic [7:0]              pri_one;
    logic [7:0]              rst_ctrl;
    logic [`PIRQ_EVT_W-1:0]  stat;
    logic [`PIRQ_EVT_W-1:0]  mask;
    logic                    wr_pend;
    logic [7:0]              addr;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic                    irq_high;
    logic                    irq_low;
    logic                    irq;
  } pirq_state_t;

endpackage

// >>> pirq_route.sv
// routes one peripheral request to the high or low core line
`timescale 1ns/1ps
module pirq_route (
  input  wire logic req,
  input  wire logic en,
  input  wire logic prio,
  input  wire logic prio_on,
  output logic      to_high,
  output logic      to_low
);
  logic act;

  assign act     = req & en;
  // single level mode sends everything to the high line
  assign to_high = act & (~prio_on | prio);
  assign to_low  = act & prio_on & ~prio;
endmodule

// >>> pirq_src_model.sv
// peripheral request sources standing in front of the irq block
`timescale 1ns/1ps
module pirq_src_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [8:0] want,
  input  wire logic [2:0] want_pri,
  output logic      [5:0] pend_one,
  output logic      [2:0] pend_two,
  output logic      [2:0] prio_two
);
  ////////////////////////////////////////////////////////////////////////////
  // requests are level and change only after a clock edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_one <= 6'h00;
      pend_two <= 3'h0;
      prio_two <= 3'h0;
    end else begin
      pend_one <= want[5:0];
      pend_two <= want[8:6];
      prio_two <= want_pri;
    end
  end
endmodule

// >>> pirq_tb.sv
// self-checking bench of the peripheral irq block
`timescale 1ns/1ps
`include "pirq_cfg.svh"
`define TB_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
  end end
module testbench;
  import pirq_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pend_two, prio_two, want_pri;
  logic [5:0]  pend_one;
  logic [8:0]  want;
  logic        core_irq_high, core_irq_low, irq;
  int          err_count, comparisons;
  assign hready = hreadyout;
  logic [1:0]  lines;
  assign lines = {core_irq_high, core_irq_low};
  pirq_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pend_one(pend_one), .pend_two(pend_two), .prio_two(prio_two),
    .core_irq_high(core_irq_high), .core_irq_low(core_irq_low), .irq(irq));
  pirq_src_model src (.hclk(hclk), .hresetn(hresetn), .want(want),
    .want_pri(want_pri), .pend_one(pend_one), .pend_two(pend_two),
    .prio_two(prio_two));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= `PIRQ_HSIZE_WORD;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    `TB_CHK({hresp, hreadyout}, 2'h1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `TB_CHK(q, e)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // expected {high, low} lines from requests and register contents
  function automatic logic [1:0] route(input logic [8:0] w,
    input logic [2:0] p2, input logic [7:0] en, input logic [7:0] pr,
    input logic g);
    logic [8:0] req, lvl;
    req = {w[8:6] & {en[7], en[5], en[2]}, w[5:0]};
    lvl = {p2, pr[6], pr[5], pr[4], pr[2], pr[1], pr[0]};
    if (!g) return {|req, 1'b0};
    return {|(req & lvl), |(req & ~lvl)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(`PIRQ_OFF_EN_TWO, 32'h00);
    rd_chk(`PIRQ_OFF_PRI_ONE, 32'h77);
    rd_chk(`PIRQ_OFF_RST_CTRL, 32'h00);
    wr(`PIRQ_OFF_EN_TWO, 32'hffff_ffff);
    rd_chk(`PIRQ_OFF_EN_TWO, 32'ha4);
    wr(`PIRQ_OFF_PRI_ONE, 32'h0000_00ff);
    rd_chk(`PIRQ_OFF_PRI_ONE, 32'h77);
    wr(`PIRQ_OFF_PRI_ONE, 32'h0000_0088);
    rd_chk(`PIRQ_OFF_PRI_ONE, 32'h00);
    wr(`PIRQ_OFF_RST_CTRL, 32'h0000_00ff);
    rd_chk(`PIRQ_OFF_RST_CTRL, 32'h80);
    wr(8'h40, 32'h0000_00ff);
    rd_chk(8'h40, 32'h00);
  endtask
  task automatic t_route();
    logic [7:0] pr, en;
    logic [2:0] p2;
    logic [1:0] ex;
    int g, p, i;
    for (g = 0; g < 2; g++) begin
      wr(`PIRQ_OFF_RST_CTRL, g ? 32'h80 : 32'h00);
      for (p = 0; p < 2; p++) begin
        pr = p ? 8'h62 : 8'h15;
        p2 = p ? 3'h2 : 3'h5;
        wr(`PIRQ_OFF_PRI_ONE, {24'h0, pr});
        want_pri <= p2;
        for (i = 0; i < 10; i++) begin
          want <= (i == 9) ? 9'h1ff : 9'h001 << i;
          settle(3);
          ex = route(want, p2, 8'ha4, pr, g[0]);
          `TB_CHK(lines, ex)
        end
      end
    end
    for (i = 0; i < 4; i++) begin
      en = 8'h80 >> (i * 2 + (i > 1 ? 1 : 0)) & 8'ha4;
      wr(`PIRQ_OFF_EN_TWO, {24'h0, en});
      want <= 9'h1c0;
      settle(3);
      ex = route(want, p2, en, pr, 1'b1);
      `TB_CHK(lines, ex)
    end
  endtask
  task automatic t_irq();
    want <= 9'h000;
    wr(`PIRQ_OFF_PRI_ONE, 32'h00);
    wr(`PIRQ_OFF_MASK, 32'h01);
    wr(`PIRQ_OFF_STAT, 32'h03);
    settle(2);
    rd_chk(`PIRQ_OFF_STAT, 32'h03);
    rd_chk(`PIRQ_OFF_STAT, 32'h00);
    want <= 9'h001;
    settle(3);
    `TB_CHK(irq, 1'b1)
    rd_chk(`PIRQ_OFF_STAT, 32'h01);
    settle(2);
    `TB_CHK(irq, 1'b0)
    want <= 9'h000;
    wr(`PIRQ_OFF_PRI_ONE, 32'h01);
    want <= 9'h001;
    settle(3);
    `TB_CHK({core_irq_high, irq}, 2'h2)
    rd_chk(`PIRQ_OFF_STAT, 32'h02);
    rd_chk(`PIRQ_OFF_MASK, 32'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    want = 9'h000;
    want_pri = 3'h0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_route();
    t_irq();
    end_of_test();
  end
endmodule

// >>> pirq_top.sv
// peripheral irq enable/priority registers with ahb-lite slave
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pirq_cfg.svh"
module pirq_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [5:0]  pend_one,
  input  wire logic [2:0]  pend_two,
  input  wire logic [2:0]  prio_two,
  output logic             core_irq_high,
  output logic             core_irq_low,
  output logic             irq
);
  import pirq_pkg::*;

  pirq_pkg::pirq_state_t s;
  pirq_pkg::pirq_state_t n;

  logic [`PIRQ_NUM_SRC-1:0] req_all;
  logic [`PIRQ_NUM_SRC-1:0] en_all;
  logic [`PIRQ_NUM_SRC-1:0] prio_all;
  logic [`PIRQ_NUM_SRC-1:0] hi_all;
  logic [`PIRQ_NUM_SRC-1:0] lo_all;
  logic                     gpe;

  //////////////////////////////////////////////////////////////////////////
  // source routing

  assign gpe     = s.rst_ctrl[`PIRQ_BIT_GLOBAL_PRI];
  assign req_all = {pend_two, pend_one};
  // enables of the first group live outside, requests arrive pre-gated
  assign en_all  = {s.en_two[`PIRQ_BIT_OSC_FAIL_EN],
                    s.en_two[`PIRQ_BIT_USB_EN],
                    s.en_two[`PIRQ_BIT_VDET_EN],
                    6'h3f};
  // second group takes its level from the external priority register
  assign prio_all = {prio_two,
                     s.pri_one[`PIRQ_BIT_CONV_PRI],
                     s.pri_one[`PIRQ_BIT_SRX_PRI],
                     s.pri_one[`PIRQ_BIT_STX_PRI],
                     s.pri_one[`PIRQ_BIT_CCMP_PRI],
                     s.pri_one[`PIRQ_BIT_TMATCH_PRI],
                     s.pri_one[`PIRQ_BIT_TOVF_PRI]};

  for (genvar i = 0; i < `PIRQ_NUM_SRC; i++) begin : g_src
    pirq_route u_route (
      .req     (req_all[i]),
      .en      (en_all[i]),
      .prio    (prio_all[i]),
      .prio_on (gpe),
      .to_high (hi_all[i]),
      .to_low  (lo_all[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic                   acc;
    logic [31:0]            rd;
    logic [`PIRQ_EVT_W-1:0] set;
    logic [`PIRQ_EVT_W-1:0] clr;
    acc = hsel & hready & htrans[1];
    rd  = 32'h0;
    set = '0;
    clr = '0;
    n   = s;
    // data phase of an accepted write
    if (s.wr_pend) begin
      case (s.addr)
        `PIRQ_OFF_EN_TWO:
          n.en_two = hwdata[7:0] & `PIRQ_EN_TWO_MASK;
        `PIRQ_OFF_PRI_ONE:
          n.pri_one = hwdata[7:0] & `PIRQ_PRI_ONE_MASK;
        `PIRQ_OFF_RST_CTRL:
          n.rst_ctrl = hwdata[7:0] & `PIRQ_RST_CTRL_MASK;
        `PIRQ_OFF_MASK:
          n.mask = hwdata[`PIRQ_EVT_W-1:0];
        default: begin
        end
      endcase
    end
    n.wr_pend = acc & hwrite & (hsize == `PIRQ_HSIZE_WORD);
    if (acc) begin
      n.addr = haddr[7:0];
    end
    // read data reflects a write finishing in this same cycle
    if (acc && !hwrite) begin
      case (haddr[7:0])
        `PIRQ_OFF_EN_TWO:   rd = {24'h0, n.en_two};
        `PIRQ_OFF_PRI_ONE:  rd = {24'h0, n.pri_one};
        `PIRQ_OFF_RST_CTRL: rd = {24'h0, n.rst_ctrl};
        `PIRQ_OFF_STAT: begin
          rd  = {30'h0, s.stat};
          clr = s.stat;
        end
        `PIRQ_OFF_MASK:     rd = {30'h0, n.mask};
        default:            rd = 32'h0;
      endcase
    end
    n.hrdata    = rd;
    n.hreadyout = 1'b1;
    n.hresp     = 1'b0;
    n.irq_high  = |hi_all;
    n.irq_low   = |lo_all;
    set[`PIRQ_EVT_HIGH] = n.irq_high & ~s.irq_high;
    set[`PIRQ_EVT_LOW]  = n.irq_low & ~s.irq_low;
    // a new event beats the read clear
    n.stat = (s.stat & ~clr) | set;
    n.irq  = |(n.stat & n.mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.en_two    <= `PIRQ_EN_TWO_RST;
      s.pri_one   <= `PIRQ_PRI_ONE_RST;
      s.rst_ctrl  <= `PIRQ_RST_CTRL_RST;
      s.stat      <= '0;
      s.mask      <= `PIRQ_EVT_MASK_RST;
      s.wr_pend   <= 1'b0;
      s.addr      <= 8'h0;
      s.hrdata    <= 32'h0;
      s.hreadyout <= 1'b1;
      s.hresp     <= 1'b0;
      s.irq_high  <= 1'b0;
      s.irq_low   <= 1'b0;
      s.irq       <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign hreadyout     = s.hreadyout;
  assign hresp         = s.hresp;
  assign hrdata        = s.hrdata;
  assign core_irq_high = s.irq_high;
  assign core_irq_low  = s.irq_low;
  assign irq           = s.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [2:0] en_two_bits;
  assign en_two_bits = {s.en_two[`PIRQ_BIT_OSC_FAIL_EN],
                        s.en_two[`PIRQ_BIT_USB_EN],
                        s.en_two[`PIRQ_BIT_VDET_EN]};

  logic       bus_rd;
  assign bus_rd = hsel & hready & htrans[1] & ~hwrite;

  en_two_write_a: assert property (
    (s.wr_pend && s.addr == `PIRQ_OFF_EN_TWO) |=>
      (s.en_two == ($past(hwdata[7:0]) & `PIRQ_EN_TWO_MASK)))
    else $error("enable two write not stored");

  unimpl_zero_a: assert property (
    ((s.en_two & ~`PIRQ_EN_TWO_MASK) == 8'h0) &&
    ((s.pri_one & ~`PIRQ_PRI_ONE_MASK) == 8'h0) &&
    (s.hrdata[31:8] == 24'h0))
    else $error("unimplemented bit reads non-zero");

  pri_one_write_a: assert property (
    (s.wr_pend && s.addr == `PIRQ_OFF_PRI_ONE) |=>
      (s.pri_one == ($past(hwdata[7:0]) & `PIRQ_PRI_ONE_MASK)))
    else $error("priority one write not stored");

  timer_match_low_a: assert property (
    (pend_one == 6'h02 && pend_two == 3'h0 && gpe &&
     !s.pri_one[`PIRQ_BIT_TMATCH_PRI]) |=> (core_irq_low && !core_irq_high))
    else $error("timer match low priority misrouted");

  second_group_prio_a: assert property (
    (pend_one == 6'h00 && pend_two == 3'h2 && gpe &&
     s.en_two[`PIRQ_BIT_USB_EN] && !prio_two[1]) |=>
      (core_irq_low && !core_irq_high))
    else $error("second group priority not honoured");

  single_level_a: assert property (
    !gpe |=> !core_irq_low)
    else $error("low line used without priority enable");

  gpe_write_a: assert property (
    (s.wr_pend && s.addr == `PIRQ_OFF_RST_CTRL) |=>
      (gpe == $past(hwdata[`PIRQ_BIT_GLOBAL_PRI])))
    else $error("priority enable write not stored");

  disabled_block_a: assert property (
    (pend_one == 6'h00 && (pend_two & en_two_bits) == 3'h0) |=>
      (!core_irq_high && !core_irq_low))
    else $error("disabled request reached the core");

  // only an event in the clearing cycle may survive a status read
  stat_read_a: assert property (
    (bus_rd && haddr[7:0] == `PIRQ_OFF_STAT) |=>
      (s.stat == {s.irq_high & ~$past(s.irq_high),
                  s.irq_low & ~$past(s.irq_low)}))
    else $error("status not cleared by read");

  irq_level_a: assert property (
    irq == |(s.stat & s.mask))
    else $error("interrupt output mismatch");

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");

  zero_wait_a: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");

  read_en_two_a: assert property (
    (bus_rd && haddr[7:0] == `PIRQ_OFF_EN_TWO) |=>
      (hrdata == {24'h0, s.en_two}))
    else $error("enable two read data wrong");

  read_pri_one_a: assert property (
    (bus_rd && haddr[7:0] == `PIRQ_OFF_PRI_ONE) |=>
      (hrdata == {24'h0, s.pri_one}))
    else $error("priority one read data wrong");

  read_gpe_a: assert property (
    (bus_rd && haddr[7:0] == `PIRQ_OFF_RST_CTRL) |=>
      (hrdata == {24'h0, gpe, 7'h0}))
    else $error("reset control read data wrong");

  read_unmapped_a: assert property (
    (bus_rd && haddr[7:0] > `PIRQ_OFF_MASK) |=>
      (hrdata == 32'h0))
    else $error("unmapped offset read non-zero");

  read_idle_a: assert property (
    !bus_rd |=>
      (hrdata == 32'h0))
    else $error("read data outside data phase");

  low_route_a: assert property (
    (pend_one == 6'h04 && pend_two == 3'h0 && gpe &&
     !s.pri_one[`PIRQ_BIT_CCMP_PRI]) |=> (core_irq_low && !core_irq_high))
    else $error("low priority request misrouted");

  high_route_a: assert property (
    (pend_one == 6'h01 && pend_two == 3'h0 && gpe &&
     s.pri_one[`PIRQ_BIT_TOVF_PRI]) |=> (core_irq_high && !core_irq_low))
    else $error("high priority request misrouted");

  single_high_a: assert property (
    (!gpe && pend_one != 6'h00) |=>
      core_irq_high)
    else $error("single level request not on high line");

  osc_low_route_a: assert property (
    (s.en_two[`PIRQ_BIT_OSC_FAIL_EN] && pend_two[2] && !prio_two[2] &&
     gpe) |=> core_irq_low)
    else $error("enabled osc fail request lost");

  usb_high_route_a: assert property (
    (pend_one == 6'h00 && pend_two == 3'h2 && gpe &&
     s.en_two[`PIRQ_BIT_USB_EN] && prio_two[1]) |=>
      (core_irq_high && !core_irq_low))
    else $error("usb high priority not honoured");

  stat_high_set_a: assert property (
    $rose(core_irq_high) |->
      s.stat[`PIRQ_EVT_HIGH])
    else $error("high line rise not flagged");

  stat_low_set_a: assert property (
    $rose(core_irq_low) |->
      s.stat[`PIRQ_EVT_LOW])
    else $error("low line rise not flagged");

  stat_sticky_a: assert property (
    !(bus_rd && haddr[7:0] == `PIRQ_OFF_STAT) |=>
      ((s.stat & $past(s.stat)) == $past(s.stat)))
    else $error("status bit lost without read");

  mask_write_a: assert property (
    (s.wr_pend && s.addr == `PIRQ_OFF_MASK) |=>
      (s.mask == $past(hwdata[`PIRQ_EVT_W-1:0])))
    else $error("mask write not stored");

  high_route_c: cover property (core_irq_high && gpe);
  low_route_c:  cover property (core_irq_low);
  irq_fire_c:   cover property ($rose(irq));
  stat_read_c:  cover property (s.addr == `PIRQ_OFF_STAT && s.stat != 2'h0);

endmodule
